/* src/cpf_protector.sv */
`timescale 1ns/1ps
// Operation
// [RULE1] Overvoltage code selects 4.275 to 4.450 V
// [RULE2] Charge overcurrent code selects 6 to 28 mV
// [RULE3] Discharge overcurrent code selects 14 to 83 mV
// [RULE4] Short-circuit bit selects 73 or 148 mV
// [RULE5] Normal mode closes both FETs, keeps checking
// [RULE6] Firmware may force each FET open separately
// [RULE7] Fault modes own FETs; firmware cannot close
// [RULE8] Firmware only opens FETs or releases override
// [RULE9] Shutdown command sets intent, enters shutdown-wait
// [RULE10] Sustained overvoltage enters fault, enables removal detect
// [RULE11] Overvoltage clears on pack low and release
// [RULE12] Sustained undervoltage faults; no charger means shutdown
// [RULE13] Undervoltage clears on charger and release level
// [RULE14] Undervoltage reachable from low-voltage charging and normal
// [RULE15] Sustained charge overcurrent enters its fault mode
// [RULE16] Charge overcurrent clears when pack drops low
// [RULE17] Sustained discharge overcurrent or short raises fault
// [RULE18] Discharge fault clears when pack returns near
// [RULE19] Shutdown-wait opens FETs, checks faults, awaits removal
// [RULE20] Charger in shutdown: low-voltage charging or normal
// [RULE21] Low-voltage charging ties gate only above detect
// [RULE22] Thresholds come from two stored configuration words
// [RULE23] Faults open FETs; clearing re-enables them
// [RULE24] Delay timer restarts whenever its condition lapses
// [RULE25] Threshold selects sampled only outside fault modes
module cpf_protector #(
  parameter logic [23:0] OV_DLY  = cpf_pkg::OV_DLY_CYC,
  parameter logic [23:0] UV_DLY  = cpf_pkg::UV_DLY_CYC,
  parameter logic [23:0] OCC_DLY = cpf_pkg::OCC_DLY_CYC,
  parameter logic [23:0] OCD_DLY = cpf_pkg::OCD_DLY_CYC,
  parameter logic [23:0] SCD_DLY = cpf_pkg::SCD_DLY_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [4:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        cell_over_ov,       // Cell above overvoltage_threshold
  input  wire logic        cell_below_ovrel,   // Cell below overvoltage_release_level
  input  wire logic        cell_below_uv,      // Cell below undervoltage_threshold
  input  wire logic        cell_above_uvrel,   // Cell above undervoltage_release_level
  input  wire logic        sense_over_occ,     // Sense above charge threshold
  input  wire logic        sense_over_ocd,     // Sense above discharge threshold
  input  wire logic        sense_over_scd,     // Sense above short-circuit threshold
  input  wire logic        pack_low,           // pack_plus_node over 300 mV below cell
  input  wire logic        charger_present,    // Charger detector
  input  wire logic        cell_below_por,     // Cell below power-on reset level
  input  wire logic        cell_above_lvdet,   // Cell above low_voltage_detect_level
  output logic             chg_fet_on,
  output logic             dsg_fet_on,
  output logic             chg_gate_to_pack,
  output logic             regulator_off,
  output logic             removal_det_en,
  output logic             charger_det_en,
  output logic [12:0]      ov_threshold_mv,
  output logic [7:0]       occ_threshold_mv,
  output logic [7:0]       ocd_threshold_mv,
  output logic [7:0]       scd_threshold_mv
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    cpf_pkg::cpf_mode_e mode;     // Protector mode
    logic               shd_chk;  // Shutdown-wait past its FET-open step
    logic               shd_int;  // shutdown_intent_bit
    logic [4:0][23:0]   tmr;      // Fault delay timers
    logic [4:0]         evt;      // Sticky fault events
    logic [2:0]         vset;     // Stored overvoltage select
    logic [5:0]         cset;     // Stored current selects
    logic [1:0]         fw;       // Firmware open override
    logic [12:0]        ov_mv;    // Active thresholds
    logic [7:0]         occ_mv;
    logic [7:0]         ocd_mv;
    logic [7:0]         scd_mv;
    logic               chg_on;   // FET and regulator drives
    logic               dsg_on;
    logic               lv_gate;
    logic               reg_off;
    logic               aw_ok;    // AXI write slave
    logic               w_ok;
    logic [4:0]         awa;
    logic [7:0]         wd;
    logic               wstb;
    logic               bv;
    logic [1:0]         br;
    logic               rv;       // AXI read slave
    logic [31:0]        rd;
    logic [1:0]         rr;
  } cpf_st_s;

  cpf_st_s r;          // Registered state
  cpf_st_s r_nxt;      // Next state
  logic [4:0] cond;    // Raw fault conditions
  logic [4:0] hit;     // Conditions that outlasted their delay
  logic [4:0] clr;     // Event clear mask
  logic       shd_cmd; // Shutdown command pulse
  logic       hw_chg;  // Hardware allows charge FET
  logic       hw_dsg;  // Hardware allows discharge FET

  localparam logic [4:0][23:0] DLY = {SCD_DLY, OCD_DLY, OCC_DLY, UV_DLY, OV_DLY};

  // ****************************************
  // Helpers
  // ****************************************
  // True in a hardware protection fault mode
  function automatic logic is_fault(input cpf_pkg::cpf_mode_e m);
    is_fault = (m == cpf_pkg::M_OVP) || (m == cpf_pkg::M_UVP) ||
               (m == cpf_pkg::M_OCC) || (m == cpf_pkg::M_OCD);
  endfunction : is_fault

  // Overvoltage code to millivolts
  function automatic logic [12:0] ov_lut(input logic [2:0] c);
    ov_lut = cpf_pkg::OV_BASE_MV + 13'(cpf_pkg::OV_STEP_MV * c);
  endfunction : ov_lut

  // Register read mux; flags unmapped offsets
  function automatic logic [32:0] rd_word(input logic [4:0] a, input cpf_st_s s);
    rd_word = '0;
    case (a)
      cpf_pkg::VPROT_OFS: rd_word[2:0] = s.vset;
      cpf_pkg::CPROT_OFS: rd_word[5:0] = s.cset;
      cpf_pkg::CTRL_OFS:  rd_word[1:0] = s.fw;
      cpf_pkg::STAT_OFS:  rd_word[7:0] = {s.lv_gate, s.reg_off, s.shd_int, s.dsg_on,
                                           s.chg_on, s.mode};
      cpf_pkg::EVT_OFS:   rd_word[4:0] = s.evt;
      default:            rd_word[32] = 1'b1;
    endcase
  endfunction : rd_word

  // ****************************************
  // Outputs
  // ****************************************
  assign awready          = !r.aw_ok && !r.bv;
  assign wready           = !r.w_ok && !r.bv;
  assign bvalid           = r.bv;
  assign bresp            = r.br;
  assign arready          = !r.rv;
  assign rvalid           = r.rv;
  assign rdata            = r.rd;
  assign rresp            = r.rr;
  assign chg_fet_on       = r.chg_on;
  assign dsg_fet_on       = r.dsg_on;
  assign chg_gate_to_pack = r.lv_gate;
  assign regulator_off    = r.reg_off;
  assign removal_det_en   = (r.mode == cpf_pkg::M_OVP);  // [RULE10]
  assign charger_det_en   = (r.mode == cpf_pkg::M_UVP);  // [RULE12]
  assign ov_threshold_mv  = r.ov_mv;
  assign occ_threshold_mv = r.occ_mv;
  assign ocd_threshold_mv = r.ocd_mv;
  assign scd_threshold_mv = r.scd_mv;

  assign cond = {sense_over_scd, sense_over_ocd, sense_over_occ, cell_below_uv, cell_over_ov};

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic [32:0] rw;
    rw      = '0;
    r_nxt   = r;
    clr     = '0;
    shd_cmd = 1'b0;
    hw_chg  = 1'b0;
    hw_dsg  = 1'b0;
    // Fault delay timers, restart on any lapse
    for (int i = 0; i < 5; i++) begin
      hit[i] = cond[i] && (r.tmr[i] == DLY[i]);
      if (!cond[i]) begin
        r_nxt.tmr[i] = '0;  // [RULE24]
      end else if (!hit[i]) begin
        r_nxt.tmr[i] = r.tmr[i] + 24'h000001;
      end
    end
    // Write address and data, taken in either order
    if (awvalid && awready) begin
      r_nxt.aw_ok = 1'b1;
      r_nxt.awa   = awaddr;
    end
    if (wvalid && wready) begin
      r_nxt.w_ok = 1'b1;
      r_nxt.wd   = wdata[7:0];
      r_nxt.wstb = wstrb[0];
    end
    // Commit write once both halves are held
    if (r.aw_ok && r.w_ok) begin
      r_nxt.aw_ok = 1'b0;
      r_nxt.w_ok  = 1'b0;
      r_nxt.bv    = 1'b1;
      r_nxt.br    = cpf_pkg::RESP_OKAY;
      case (r.awa)
        cpf_pkg::VPROT_OFS: if (r.wstb) r_nxt.vset = r.wd[2:0];  // [RULE22]
        cpf_pkg::CPROT_OFS: if (r.wstb) r_nxt.cset = r.wd[5:0];  // [RULE22]
        cpf_pkg::CTRL_OFS: begin
          // Override bits can only open FETs or release
          if (r.wstb) r_nxt.fw = {r.wd[cpf_pkg::CTL_DSG], r.wd[cpf_pkg::CTL_CHG]};  // [RULE8]
          shd_cmd = r.wstb && r.wd[cpf_pkg::CTL_SHD];
        end
        cpf_pkg::STAT_OFS: ;
        cpf_pkg::EVT_OFS: if (r.wstb) clr = r.wd[4:0];
        default: r_nxt.br = cpf_pkg::RESP_SLVERR;
      endcase
    end else if (r.bv && bready) begin
      r_nxt.bv = 1'b0;
    end
    // Read channel
    if (arvalid && arready) begin
      rw      = rd_word(araddr, r);
      r_nxt.rv = 1'b1;
      r_nxt.rd = rw[31:0];
      r_nxt.rr = rw[32] ? cpf_pkg::RESP_SLVERR : cpf_pkg::RESP_OKAY;
    end else if (r.rv && rready) begin
      r_nxt.rv = 1'b0;
    end
    // Sticky events, set wins over clear
    r_nxt.evt = (r.evt & ~clr) | hit;
    // Mode sequencing
    case (r.mode)
      cpf_pkg::M_NORMAL: begin
        // Every condition watched continuously
        if (hit[cpf_pkg::F_SCD] || hit[cpf_pkg::F_OCD]) begin
          r_nxt.mode = cpf_pkg::M_OCD;  // [RULE17]
        end else if (hit[cpf_pkg::F_OCC]) begin
          r_nxt.mode = cpf_pkg::M_OCC;  // [RULE15]
        end else if (hit[cpf_pkg::F_OV]) begin
          r_nxt.mode = cpf_pkg::M_OVP;  // [RULE10]
        end else if (hit[cpf_pkg::F_UV]) begin
          r_nxt.mode = cpf_pkg::M_UVP;  // [RULE14]
        end else if (shd_cmd) begin
          r_nxt.mode    = cpf_pkg::M_SHDW;  // [RULE9]
          r_nxt.shd_int = 1'b1;             // [RULE9]
          r_nxt.shd_chk = 1'b0;
        end
      end
      cpf_pkg::M_OVP: begin
        // Charger removed and cell relaxed
        if (pack_low && cell_below_ovrel) r_nxt.mode = cpf_pkg::M_NORMAL;  // [RULE11]
      end
      cpf_pkg::M_UVP: begin
        if (!charger_present) begin
          r_nxt.mode    = cpf_pkg::M_ASHD;  // [RULE12]
          r_nxt.reg_off = 1'b1;
        end else if (cell_above_uvrel) begin
          r_nxt.mode = cpf_pkg::M_NORMAL;  // [RULE13]
        end
      end
      cpf_pkg::M_OCC: begin
        if (pack_low) r_nxt.mode = cpf_pkg::M_NORMAL;  // [RULE16]
      end
      cpf_pkg::M_OCD: begin
        if (!pack_low) r_nxt.mode = cpf_pkg::M_NORMAL;  // [RULE18]
      end
      cpf_pkg::M_SHDW: begin
        // First cycle opens both FETs, then checks
        if (!r.shd_chk) begin
          r_nxt.shd_chk = 1'b1;  // [RULE19]
        end else if (|hit) begin
          r_nxt.mode    = cpf_pkg::M_NORMAL;  // [RULE19]
          r_nxt.shd_int = 1'b0;
        end else if (!charger_present) begin
          r_nxt.mode    = cpf_pkg::M_ASHD;  // [RULE19]
          r_nxt.reg_off = 1'b1;
        end
      end
      cpf_pkg::M_ASHD: begin
        // Charger attach wakes the regulator
        if (charger_present && cell_below_por) begin
          r_nxt.mode    = cpf_pkg::M_LVCHG;  // [RULE20]
          r_nxt.reg_off = 1'b0;
        end else if (charger_present && !(|cond)) begin
          r_nxt.mode    = cpf_pkg::M_NORMAL;  // [RULE20]
          r_nxt.reg_off = 1'b0;
          r_nxt.shd_int = 1'b0;
        end
      end
      cpf_pkg::M_LVCHG: begin
        if (hit[cpf_pkg::F_UV]) r_nxt.mode = cpf_pkg::M_UVP;  // [RULE14]
      end
      default: r_nxt.mode = cpf_pkg::M_NORMAL;
    endcase
    // FET drive from next mode, override only opens
    case (r_nxt.mode)
      cpf_pkg::M_NORMAL: begin
        hw_chg = 1'b1;  // [RULE5]
        hw_dsg = 1'b1;  // [RULE5]
      end
      cpf_pkg::M_OVP, cpf_pkg::M_OCC: hw_dsg = 1'b1;  // [RULE23]
      cpf_pkg::M_UVP, cpf_pkg::M_OCD: hw_chg = 1'b1;  // [RULE23]
      default: ;
    endcase
    r_nxt.chg_on  = hw_chg && !r_nxt.fw[0];  // [RULE6] [RULE7]
    r_nxt.dsg_on  = hw_dsg && !r_nxt.fw[1];  // [RULE6] [RULE7]
    r_nxt.lv_gate = (r_nxt.mode == cpf_pkg::M_LVCHG) && cell_above_lvdet;  // [RULE21]
    // Thresholds frozen through a fault episode
    if (!is_fault(r.mode)) begin
      r_nxt.ov_mv  = ov_lut(r.vset);  // [RULE25] [RULE1]
      r_nxt.occ_mv = cpf_pkg::OCC_MV[r.cset[cpf_pkg::OCC_LSB +: 2]];  // [RULE2]
      r_nxt.ocd_mv = cpf_pkg::OCD_MV[r.cset[cpf_pkg::OCD_LSB +: 3]];  // [RULE3]
      r_nxt.scd_mv = cpf_pkg::SCD_MV[r.cset[cpf_pkg::SCD_BIT]];       // [RULE4]
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r        <= '0;
      r.mode   <= cpf_pkg::M_NORMAL;
      r.vset   <= cpf_pkg::VPROT_RST;
      r.cset   <= cpf_pkg::CPROT_RST;
      r.ov_mv  <= ov_lut(cpf_pkg::VPROT_RST);
      r.occ_mv <= cpf_pkg::OCC_MV[cpf_pkg::CPROT_RST[cpf_pkg::OCC_LSB +: 2]];
      r.ocd_mv <= cpf_pkg::OCD_MV[cpf_pkg::CPROT_RST[cpf_pkg::OCD_LSB +: 3]];
      r.scd_mv <= cpf_pkg::SCD_MV[cpf_pkg::CPROT_RST[cpf_pkg::SCD_BIT]];
    end else begin
      r <= r_nxt;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_calm;
    (r.mode == cpf_pkg::M_NORMAL);
  endsequence

  sequence s_enter_shdw;
    s_calm ##0 (shd_cmd && !(|hit));
  endsequence

  ov_lookup_a: assert property (s_calm |=> r.ov_mv == 13'h10B3 + 13'(13'h0019 * $past(r.vset))) // [RULE1]
    else $error("overvoltage threshold wrong");
  occ_lookup_a: assert property (s_calm ##0 r.cset[1:0] == 2'h2 |=> r.occ_mv == 8'h12) // [RULE2]
    else $error("charge threshold wrong");
  ocd_lookup_a: assert property (s_calm ##0 r.cset[4:2] == 3'h7 |=> r.ocd_mv == 8'h53) // [RULE3]
    else $error("discharge threshold wrong");
  scd_lookup_a: assert property (s_calm ##0 r.cset[5] |=> r.scd_mv == 8'h94) // [RULE4]
    else $error("short threshold wrong");
  normal_fets_a: assert property (s_calm ##0 r.fw == 2'h0 ##0 $past(aresetn) // [RULE5]
                                  |-> chg_fet_on && dsg_fet_on)
    else $error("normal mode FETs not closed");
  fw_open_a: assert property (r.fw[0] |-> !chg_fet_on) // [RULE6]
    else $error("override did not open charge FET");
  fault_owns_a: assert property (r.mode == cpf_pkg::M_OVP || r.mode == cpf_pkg::M_OCC
                                 |-> !chg_fet_on) // [RULE7]
    else $error("charge FET closed in fault");
  shd_entry_a: assert property (s_enter_shdw |=> r.mode == cpf_pkg::M_SHDW && r.shd_int) // [RULE9]
    else $error("shutdown command not taken");
  ov_entry_a: assert property (s_calm ##0 hit == 5'h01 |=> r.mode == cpf_pkg::M_OVP
                               ##0 removal_det_en) // [RULE10]
    else $error("overvoltage fault not entered");
  timer_restart_a: assert property (!cond[0] |=> r.tmr[0] == 24'h000000) // [RULE24]
    else $error("delay timer not restarted");
  shd_fets_a: assert property ($rose(r.mode == cpf_pkg::M_SHDW)
                               |-> !chg_fet_on && !dsg_fet_on && !r.shd_chk) // [RULE19]
    else $error("shutdown wait FETs not opened first");
  thr_hold_a: assert property (is_fault(r.mode) |=> $stable(r.ov_mv) && $stable(r.ocd_mv)) // [RULE25]
    else $error("threshold changed inside fault");

endmodule : cpf_protector

/* common/cpf_pkg.sv */
package cpf_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [4:0] VPROT_OFS  = 5'h00;  // voltage_protect_settings
  localparam logic [4:0] CPROT_OFS  = 5'h04;  // current_protect_settings
  localparam logic [4:0] CTRL_OFS   = 5'h08;  // Firmware override and shutdown
  localparam logic [4:0] STAT_OFS   = 5'h0C;  // Live mode and FET state
  localparam logic [4:0] EVT_OFS    = 5'h10;  // Sticky fault events, write one to clear

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int          OCC_LSB     = 0;      // charge_overcurrent_level bits
  localparam int          OCD_LSB     = 2;      // discharge_overcurrent_level bits
  localparam int          SCD_BIT     = 5;      // short_circuit_level_bit
  localparam int          CTL_CHG     = 0;      // Force charge FET open
  localparam int          CTL_DSG     = 1;      // Force discharge FET open
  localparam int          CTL_SHD     = 2;      // Shutdown command, self clearing
  localparam logic [2:0]  VPROT_RST   = 3'h7;   // 4.450 V
  localparam logic [5:0]  CPROT_RST   = 6'h0A;  // 18 mV, 34 mV, 73 mV
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ****************************************
  // Threshold lookup tables in millivolts
  // ****************************************
  localparam logic [12:0] OV_BASE_MV = 13'h10B3;  // 4275 mV
  localparam logic [12:0] OV_STEP_MV = 13'h0019;  // 25 mV
  localparam logic [3:0][7:0] OCC_MV = {8'h1C, 8'h12, 8'h0D, 8'h06};
  localparam logic [7:0][7:0] OCD_MV = {8'h53, 8'h49, 8'h3F, 8'h35,
                                        8'h2C, 8'h22, 8'h18, 8'h0E};
  localparam logic [1:0][7:0] SCD_MV = {8'h94, 8'h49};

  // ****************************************
  // Fault delays
  // ****************************************
  localparam int          CLK_MHZ     = 100;
  localparam int          OV_DLY_US   = 1000;
  localparam int          UV_DLY_US   = 1000;
  localparam int          OCC_DLY_US  = 500;
  localparam int          OCD_DLY_US  = 200;
  localparam int          SCD_DLY_US  = 2;
  localparam logic [23:0] OV_DLY_CYC  = 24'(OV_DLY_US * CLK_MHZ);
  localparam logic [23:0] UV_DLY_CYC  = 24'(UV_DLY_US * CLK_MHZ);
  localparam logic [23:0] OCC_DLY_CYC = 24'(OCC_DLY_US * CLK_MHZ);
  localparam logic [23:0] OCD_DLY_CYC = 24'(OCD_DLY_US * CLK_MHZ);
  localparam logic [23:0] SCD_DLY_CYC = 24'(SCD_DLY_US * CLK_MHZ);

  // Fault condition index
  localparam int F_OV  = 0;
  localparam int F_UV  = 1;
  localparam int F_OCC = 2;
  localparam int F_OCD = 3;
  localparam int F_SCD = 4;

  // ****************************************
  // Protector modes
  // ****************************************
  typedef enum logic [2:0] {
    M_NORMAL = 3'h0,
    M_OVP    = 3'h1,
    M_UVP    = 3'h2,
    M_OCC    = 3'h3,
    M_OCD    = 3'h4,
    M_SHDW   = 3'h5,
    M_ASHD   = 3'h6,
    M_LVCHG  = 3'h7
  } cpf_mode_e;

endpackage : cpf_pkg

/* tb/cpf_far_side.sv */
`timescale 1ns/1ps
// ****************************************
// Charger, load and pack node model
// ****************************************
module cpf_far_side (
  input  wire logic charger_attached,  // Charger plugged into the pack
  input  wire logic load_attached,     // Load pulling the pack node
  output logic      pack_low,          // Pack node well below the cell
  output logic      charger_present    // Charger detector output
);
  // A charger holds the pack up; only a load without charger drags it low
  assign pack_low        = !charger_attached && load_attached;
  assign charger_present = charger_attached;
endmodule : cpf_far_side

/* tb/cpf_protector_tb.sv */
`timescale 1ns/1ps
module cpf_protector_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, st, rd;
  logic [3:0]  wstrb = 4'hF;                  // Whole word always offered
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        ov = 1'b0, ovrel = 1'b0, uv = 1'b0, uvrel = 1'b0, por = 1'b0, lvdet = 1'b0;
  logic        occ = 1'b0, ocd = 1'b0, short_circuit_level_bit = 1'b0, chgr = 1'b0, load = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pack_low, chg_pres;
  logic        chg_on, dsg_on, gate, reg_off, rem_en, chd_en;
  logic [1:0]  bresp, rresp;
  logic [12:0] ovt;
  logic [7:0]  occt, ocdt, scdt;
  logic [7:0]  occ_t [4] = '{8'h06, 8'h0D, 8'h12, 8'h1C};   // Expected charge limits
  logic [7:0]  ocd_t [8] = '{8'h0E, 8'h18, 8'h22, 8'h2C, 8'h35, 8'h3F, 8'h49, 8'h53};
  logic [7:0]  scd_t [2] = '{8'h49, 8'h94};                 // Expected short limits
  int          error_cnt = 0, num_checks = 0;

  // Clock at 100 MHz
  always #5 aclk = ~aclk;

  cpf_protector #(.OV_DLY(24'h8), .UV_DLY(24'h8), .OCC_DLY(24'h8), .OCD_DLY(24'h8),
    .SCD_DLY(24'h8)) u_cpf_protector (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .cell_over_ov(ov), .cell_below_ovrel(ovrel), .cell_below_uv(uv),
    .cell_above_uvrel(uvrel), .sense_over_occ(occ), .sense_over_ocd(ocd),
    .sense_over_scd(short_circuit_level_bit), .pack_low, .charger_present(chg_pres), .cell_below_por(por),
    .cell_above_lvdet(lvdet), .chg_fet_on(chg_on), .dsg_fet_on(dsg_on),
    .chg_gate_to_pack(gate), .regulator_off(reg_off), .removal_det_en(rem_en),
    .charger_det_en(chd_en), .ov_threshold_mv(ovt), .occ_threshold_mv(occt),
    .ocd_threshold_mv(ocdt), .scd_threshold_mv(scdt));

  cpf_far_side u_cpf_far_side (.charger_attached(chgr), .load_attached(load),
    .pack_low(pack_low), .charger_present(chg_pres));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // Write: both halves offered together, each dropped when taken
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
                        input logic [1:0] er = cpf_pkg::RESP_OKAY);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    // Waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask : axi_wr

  // Read: address held until taken, data captured at the rvalid edge
  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d,
                        input logic [1:0] er = cpf_pkg::RESP_OKAY);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
    chk("rresp", er, rresp);
  endtask : axi_rd

  // Mode from status plus both FET pins
  task automatic ck_mode(input logic [2:0] m, input logic c, input logic g);
    axi_rd(cpf_pkg::STAT_OFS, st);
    chk("mode", m, st[2:0]);
    chk("chg_fet", c, chg_on);
    chk("dsg_fet", g, dsg_on);
  endtask : ck_mode

  task automatic final_report();
    $display("Checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  // Watchdog well beyond the expected run
  initial begin
    #500000;
    error_cnt++;
    final_report();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    cyc(4);
    aresetn <= 1'b1;
    axi_rd(cpf_pkg::VPROT_OFS, rd);
    chk("vprot", 32'h7, rd);
    axi_rd(cpf_pkg::CPROT_OFS, rd);
    chk("cprot", 32'h0A, rd);
    ck_mode(3'h0, 1'b1, 1'b1);
    chk("ov_thr", 32'h1162, ovt);
    chk("occ_thr", 32'h12, occt);
    chk("ocd_thr", 32'h22, ocdt);
    chk("scd_thr", 32'h49, scdt);
    // Every code of every lookup
    for (int i = 0; i < 8; i++) begin
      axi_wr(cpf_pkg::VPROT_OFS, 32'(i));
      axi_wr(cpf_pkg::CPROT_OFS, {26'h0, i[0], i[2:0], i[1:0]});
      cyc(2);
      chk("ov_thr", 32'h10B3 + 32'h19 * i, ovt);
      chk("occ_thr", occ_t[i % 4], occt);
      chk("ocd_thr", ocd_t[i], ocdt);
      chk("scd_thr", scd_t[i % 2], scdt);
    end
    axi_wr(cpf_pkg::VPROT_OFS, 32'h7);
    axi_wr(cpf_pkg::CPROT_OFS, 32'h0A);
    axi_wr(cpf_pkg::CTRL_OFS, 32'h1);
    ck_mode(3'h0, 1'b0, 1'b1);
    axi_wr(cpf_pkg::CTRL_OFS, 32'h2);
    ck_mode(3'h0, 1'b1, 1'b0);
    axi_wr(cpf_pkg::CTRL_OFS, 32'h0);
    ck_mode(3'h0, 1'b1, 1'b1);
    // Interrupted overvoltage never reaches the delay
    ov <= 1'b1; cyc(6); ov <= 1'b0; cyc(1); ov <= 1'b1; cyc(6); ov <= 1'b0;
    ck_mode(3'h0, 1'b1, 1'b1);
    ov <= 1'b1; cyc(12); ov <= 1'b0;
    ck_mode(3'h1, 1'b0, 1'b1);
    chk("removal_det", 32'h1, rem_en);
    axi_wr(cpf_pkg::CTRL_OFS, 32'h2);
    ck_mode(3'h1, 1'b0, 1'b0);
    axi_wr(cpf_pkg::CTRL_OFS, 32'h0);
    ck_mode(3'h1, 1'b0, 1'b1);
    axi_wr(cpf_pkg::VPROT_OFS, 32'h0); cyc(2);
    chk("ov_thr", 32'h1162, ovt);
    load <= 1'b1; cyc(4);
    ck_mode(3'h1, 1'b0, 1'b1);
    ovrel <= 1'b1; cyc(4);
    ck_mode(3'h0, 1'b1, 1'b1);
    chk("removal_det", 32'h0, rem_en);
    chk("ov_thr", 32'h10B3, ovt);
    ovrel <= 1'b0; load <= 1'b0;
    axi_wr(cpf_pkg::VPROT_OFS, 32'h7);
    occ <= 1'b1; cyc(12); occ <= 1'b0;
    ck_mode(3'h3, 1'b0, 1'b1);
    load <= 1'b1; cyc(4);
    ck_mode(3'h0, 1'b1, 1'b1);
    // Discharge overcurrent, then short circuit
    for (int k = 0; k < 2; k++) begin
      ocd <= (k == 0); short_circuit_level_bit <= (k == 1); cyc(12); ocd <= 1'b0; short_circuit_level_bit <= 1'b0;
      ck_mode(3'h4, 1'b1, 1'b0);
      load <= 1'b0; cyc(4);
      ck_mode(3'h0, 1'b1, 1'b1);
      if (k == 0) load <= 1'b1;
    end
    chgr <= 1'b1; uv <= 1'b1; cyc(12); uv <= 1'b0;
    ck_mode(3'h2, 1'b1, 1'b0);
    chk("charger_det", 32'h1, chd_en);
    chgr <= 1'b0; cyc(4);
    ck_mode(3'h6, 1'b0, 1'b0);
    chk("reg_off", 32'h1, reg_off);
    por <= 1'b1; chgr <= 1'b1; cyc(4);
    ck_mode(3'h7, 1'b0, 1'b0);
    chk("lv_gate", 32'h0, gate);
    lvdet <= 1'b1; cyc(3);
    chk("lv_gate", 32'h1, gate);
    uv <= 1'b1; cyc(12); uv <= 1'b0; por <= 1'b0; lvdet <= 1'b0;
    ck_mode(3'h2, 1'b1, 1'b0);
    uvrel <= 1'b1; cyc(4);
    ck_mode(3'h0, 1'b1, 1'b1);
    chk("charger_det", 32'h0, chd_en);
    uvrel <= 1'b0;
    // Shutdown with charger still attached
    axi_wr(cpf_pkg::CTRL_OFS, 32'h4);
    ck_mode(3'h5, 1'b0, 1'b0);
    chk("intent", 32'h1, st[5]);
    // A fault during shutdown-wait sends it back to normal
    short_circuit_level_bit <= 1'b1; cyc(12); short_circuit_level_bit <= 1'b0;
    ck_mode(3'h0, 1'b1, 1'b1);
    chk("intent", 32'h0, st[5]);
    axi_wr(cpf_pkg::CTRL_OFS, 32'h4);
    chgr <= 1'b0; cyc(4);
    ck_mode(3'h6, 1'b0, 1'b0);
    chk("reg_off", 32'h1, reg_off);
    chgr <= 1'b1; cyc(4);
    ck_mode(3'h0, 1'b1, 1'b1);
    chk("reg_off", 32'h0, reg_off);
    // Every fault kind has left its sticky event; write one clears
    axi_rd(cpf_pkg::EVT_OFS, rd);
    chk("events", 32'h1F, rd);
    axi_wr(cpf_pkg::EVT_OFS, 32'h1F);
    axi_rd(cpf_pkg::EVT_OFS, rd);
    chk("events_clr", 32'h0, rd);
    axi_rd(5'h14, rd, cpf_pkg::RESP_SLVERR);
    chk("unmapped", 32'h0, rd);
    axi_wr(5'h18, 32'h1, cpf_pkg::RESP_SLVERR);
    final_report();
  end
endmodule : cpf_protector_tb
